/* rtl/sst_pkg.sv */
package sst_pkg;
   // configuration field widths
   localparam int PRE_W = 3;
   localparam int POST_W = 2;
   localparam int WAIT_W = 8;
   localparam int CNT_W = 10;
   // reset values of the configuration
   localparam logic [PRE_W-1:0] PRE_RST = 3'h0;
   localparam logic [POST_W-1:0] POST_RST = 2'h0;
   localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;
   // auto-acknowledge value that hands acknowledge to this block
   localparam logic AUTO_ACK_OFF = 1'h0;
   // fixed offsets of the cycle, in bus clocks
   localparam logic [CNT_W-1:0] ACK_OFS = 10'h002;
   localparam logic [CNT_W-1:0] RDY_OFS = 10'h001;
   localparam logic [CNT_W-1:0] RDY_ACK_DLY = 10'h002;
   localparam logic [1:0] HOLD_CYC = 2'h3;
   // post-drive settings that stretch write cycles
   localparam logic [POST_W-1:0] POST_EXT1 = 2'h2;
   localparam logic [POST_W-1:0] POST_EXT2 = 2'h3;
   // cycle state
   typedef enum logic [2:0] {
      SST_IDLE = 3'b000,
      SST_PRE = 3'b001,
      SST_STROBE = 3'b010,
      SST_RDYW = 3'b011,
      SST_POST = 3'b100,
      SST_HOLD = 3'b101
   } sst_state_e;
endpackage

/* rtl/sst_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for the drive ready pin
module sst_sync (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // pin and synchronised level
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   // first flop feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         meta_r <= 1'h1;
         q_o <= 1'h1;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

/* rtl/sst_strobe_ack.sv */
`timescale 1ns/1ps
// Contract
// - card or drive on the shared strobes, never both
// - auto-acknowledge 0 with acknowledge generation enabled makes this block produce the acknowledge
// - read data captured wait count plus 3 clocks after strobe falls
// - strobe low for wait count plus 3 clocks
// - synchronised ready first sampled wait count plus 1 clock after strobe falls
// - post-drive 2 adds one write clock, 3 adds two
// - address and write data held 3 clocks after the post-drive clocks that follow acknowledge
// - strobes from select gated by direction; read strobe optional on write
// - separate 8-bit read and write wait counts from strobe start
// - ready handshake delays acknowledge; ack 2 to 3 clocks after ready
module sst_strobe_ack (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // bus master request
   input wire logic strobe_region_select_i,
   input wire logic write_i,
   input wire logic [31:0] wdata_i,
   output logic transfer_ack_n_o,
   output logic [31:0] rdata_o,
   output logic hold_active_o,
   // configuration
   input wire logic auto_ack_enable_i,
   input wire logic ack_generation_enable_i,
   input wire logic ready_handshake_enable_i,
   input wire logic read_on_write_i,
   input wire logic buf1_on_strobe_cycles_i,
   input wire logic buf2_on_strobe_cycles_i,
   input wire logic [sst_pkg::PRE_W-1:0] strobe_predrive_count_i,
   input wire logic [sst_pkg::POST_W-1:0] strobe_postdrive_count_i,
   input wire logic [sst_pkg::WAIT_W-1:0] read_wait_count_i,
   input wire logic [sst_pkg::WAIT_W-1:0] write_wait_count_i,
   // drive or card pins
   input wire logic drive_ready_in_i,
   input wire logic [31:0] ext_data_i,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   output logic [31:0] ext_data_o,
   output logic ext_data_oe_o,
   output logic buf1_en_n_o,
   output logic buf2_en_n_o
);
   import sst_pkg::*;

   sst_state_e state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [1:0] hold_r;
   logic wr_r;
   logic rdy_s;
   logic [CNT_W-1:0] rdy_cnt_r;
   logic rdy_seen_r;
   logic own_ack;
   logic [CNT_W-1:0] wait_ext;
   logic [CNT_W-1:0] post_len;

   // ready pin crosses into the bus clock
   sst_sync u_rdy_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .d_i(drive_ready_in_i),
      .q_o(rdy_s)
   );

   // this block owns the acknowledge only with auto-ack off and enabled
   assign own_ack = (auto_ack_enable_i == AUTO_ACK_OFF) &&
      ack_generation_enable_i;
   // per-direction wait count, widened to the counter
   assign wait_ext = wr_r ? {2'h0, write_wait_count_i}
      : {2'h0, read_wait_count_i};
   // post-drive length, writes stretched for settings 2 and 3
   always_comb begin
      post_len = {8'h00, strobe_postdrive_count_i};
      if (wr_r && strobe_postdrive_count_i == POST_EXT1) begin
         post_len = post_len + 10'h001;
      end else if (wr_r && strobe_postdrive_count_i == POST_EXT2) begin
         post_len = post_len + 10'h002;
      end
   end

   // cycle sequencer
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state_r <= SST_IDLE;
         cnt_r <= '0;
         wr_r <= 1'h0;
         hold_r <= 2'h0;
      end else begin
         unique case (state_r)
            SST_IDLE: begin
               if (strobe_region_select_i && own_ack) begin
                  wr_r <= write_i;
                  cnt_r <= {7'h00, strobe_predrive_count_i};
                  state_r <= (strobe_predrive_count_i == PRE_RST) ?
                     SST_STROBE : SST_PRE;
               end
            end
            SST_PRE: begin
               if (cnt_r <= 10'h001) begin
                  cnt_r <= '0;
                  state_r <= SST_STROBE;
               end else begin
                  cnt_r <= cnt_r - 10'h001;
               end
            end
            SST_STROBE: begin
               // strobe low for wait plus ack offset, then ack
               if (ready_handshake_enable_i &&
                   cnt_r == wait_ext + RDY_OFS && !rdy_s) begin
                  state_r <= SST_RDYW;
               end else if (cnt_r >= wait_ext + ACK_OFS) begin
                  cnt_r <= '0;
                  state_r <= SST_POST;
               end else begin
                  cnt_r <= cnt_r + 10'h001;
               end
            end
            SST_RDYW: begin
               // ack follows ready high by the fixed delay
               if (rdy_seen_r && rdy_cnt_r >= RDY_ACK_DLY) begin
                  cnt_r <= '0;
                  state_r <= SST_POST;
               end
            end
            SST_POST: begin
               if (cnt_r >= post_len) begin
                  hold_r <= HOLD_CYC;
                  state_r <= SST_HOLD;
               end else begin
                  cnt_r <= cnt_r + 10'h001;
               end
            end
            SST_HOLD: begin
               if (hold_r <= 2'h1) begin
                  hold_r <= 2'h0;
                  state_r <= SST_IDLE;
               end else begin
                  hold_r <= hold_r - 2'h1;
               end
            end
            default: state_r <= SST_IDLE;
         endcase
      end
   end

   // ready-high tracking while the cycle is stretched
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rdy_seen_r <= 1'h0;
         rdy_cnt_r <= '0;
      end else if (state_r != SST_RDYW) begin
         rdy_seen_r <= 1'h0;
         rdy_cnt_r <= '0;
      end else if (rdy_s) begin
         rdy_seen_r <= 1'h1;
         rdy_cnt_r <= rdy_cnt_r + 10'h001;
      end
   end

   // strobes: select gated with direction, read optionally on writes;
   // they stay low through the acknowledge cycle so data is still driven
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         read_strobe_n_o <= 1'h1;
         write_strobe_n_o <= 1'h1;
      end else begin
         read_strobe_n_o <= !(((state_r == SST_STROBE) ||
            (state_r == SST_RDYW)) &&
            (!wr_r || read_on_write_i));
         write_strobe_n_o <= !(((state_r == SST_STROBE) ||
            (state_r == SST_RDYW)) &&
            wr_r);
      end
   end

   // acknowledge pulse and read data capture at the end of the strobe
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         transfer_ack_n_o <= 1'h1;
         rdata_o <= 32'h0000_0000;
      end else begin
         transfer_ack_n_o <= 1'h1;
         if ((state_r == SST_STROBE && cnt_r >= wait_ext + ACK_OFS) ||
             (state_r == SST_RDYW && rdy_seen_r &&
              rdy_cnt_r >= RDY_ACK_DLY)) begin
            transfer_ack_n_o <= 1'h0;
         end
         // read data taken at the edge that sees the acknowledge low
         if (!transfer_ack_n_o && !wr_r) begin
            rdata_o <= ext_data_i;
         end
      end
   end

   // write data, address hold and buffer enables, buffers off in idle and hold
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ext_data_o <= 32'h0000_0000;
         ext_data_oe_o <= 1'h0;
         hold_active_o <= 1'h0;
         buf1_en_n_o <= 1'h1;
         buf2_en_n_o <= 1'h1;
      end else begin
         if (state_r == SST_IDLE && strobe_region_select_i && own_ack) begin
            ext_data_o <= wdata_i;
         end
         ext_data_oe_o <= wr_r && state_r != SST_IDLE;
         hold_active_o <= state_r == SST_HOLD;
         buf1_en_n_o <= !(buf1_on_strobe_cycles_i &&
            state_r != SST_IDLE && state_r != SST_HOLD);
         buf2_en_n_o <= !(buf2_on_strobe_cycles_i &&
            state_r != SST_IDLE && state_r != SST_HOLD);
      end
   end
endmodule

/* tb/sst_strobe_ack_checker.sv */
`timescale 1ns/1ps
// pin-level checks of the strobe and acknowledge logic
module sst_strobe_ack_checker (
   // clock, reset and request
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic strobe_region_select_i,
   input wire logic write_i,
   // configuration
   input wire logic read_on_write_i,
   input wire logic auto_ack_enable_i,
   input wire logic ack_generation_enable_i,
   input wire logic ready_handshake_enable_i,
   // pins and answer
   input wire logic drive_ready_in_i,
   input wire logic transfer_ack_n_o,
   input wire logic hold_active_o,
   input wire logic read_strobe_n_o,
   input wire logic write_strobe_n_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // acknowledge, strobe and hold relations
   ack_pulse_a:
      assert property (!transfer_ack_n_o |=> transfer_ack_n_o)
      else $error("acknowledge longer than one clock");
   ack_source_a:
      assert property (!transfer_ack_n_o |->
         !auto_ack_enable_i && ack_generation_enable_i)
      else $error("acknowledge while block not in charge");
   write_gate_a:
      assert property ($fell(write_strobe_n_o) |->
         strobe_region_select_i && write_i)
      else $error("write strobe without selected write");
   read_gate_a:
      assert property ($fell(read_strobe_n_o) |-> strobe_region_select_i
         && (!write_i || read_on_write_i))
      else $error("read strobe on wrong cycle");
   ack_in_strobe_a:
      assert property (!transfer_ack_n_o |->
         !(read_strobe_n_o && write_strobe_n_o))
      else $error("acknowledge outside strobe");
   strobe_release_a:
      assert property (!transfer_ack_n_o |=>
         read_strobe_n_o && write_strobe_n_o)
      else $error("strobe still low after acknowledge");
   hold_len_a:
      assert property ($rose(hold_active_o) |->
         hold_active_o [*3] ##1 !hold_active_o)
      else $error("hold not three clocks");
   ready_ack_a:
      assert property ($rose(drive_ready_in_i) && ready_handshake_enable_i
         && !read_strobe_n_o |-> ##[2:6] !transfer_ack_n_o)
      else $error("no acknowledge after ready");
endmodule
bind sst_strobe_ack sst_strobe_ack_checker u_chk (.*);

/* tb/sst_drive_model.sv */
`timescale 1ns/1ps
// one drive or card on the shared strobes
module sst_drive_model #(
   parameter logic [31:0] PAT = 32'h0
) (
   input wire logic clk_i,
   input wire logic rd_n_i,
   input wire logic slow_i,
   output logic ready_o,
   output logic [31:0] data_o
);
   int n = 0;
   initial ready_o = 1'h1;
   initial data_o = 32'h0;
   // ready held low 8 clocks when slow
   // data valid only while ready high, else the inverse pattern
   // card latch enables and busy line sit on general-purpose pins
   // pattern on all lanes; an 8-bit port reads only bits 31-24
   always @(posedge clk_i) begin
      n <= rd_n_i ? 0 : n + 1;
      ready_o <= !(slow_i && !rd_n_i && n < 8);
      data_o <= (!rd_n_i && ready_o) ? PAT : ~PAT;
   end
endmodule

/* tb/tb_sst_strobe_ack.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb_sst_strobe_ack;
   import sst_pkg::*;
   localparam logic [31:0] PAT = 32'ha5c3_7e18;
   logic ref_clk_i = 1'h0, resetn_i = 1'h0, strobe_region_select_i = 1'h0;
   logic write_i = 1'h0, auto_ack_enable_i = 1'h0, slow = 1'h0;
   logic ack_generation_enable_i = 1'h1, ready_handshake_enable_i = 1'h0;
   logic read_on_write_i = 1'h0, buf1_on_strobe_cycles_i = 1'h0;
   logic buf2_on_strobe_cycles_i = 1'h1, rsl;
   logic [PRE_W-1:0] strobe_predrive_count_i = 3'h0;
   logic [POST_W-1:0] strobe_postdrive_count_i = 2'h0;
   logic [WAIT_W-1:0] read_wait_count_i = 8'h00, write_wait_count_i = 8'h01;
   logic [31:0] wdata_i = 32'h1234_5678, rdata_o, ext_data_i, ext_data_o;
   logic drive_ready_in_i, transfer_ack_n_o, hold_active_o, ext_data_oe_o;
   logic read_strobe_n_o, write_strobe_n_o, buf1_en_n_o, buf2_en_n_o;
   int mismatches = 0, n_compared = 0, lo, tl, base;
   sst_strobe_ack u_dut (.*);
   sst_drive_model #(.PAT(PAT)) u_drv (.clk_i(ref_clk_i),
      .rd_n_i(read_strobe_n_o), .slow_i(slow), .ready_o(drive_ready_in_i),
      .data_o(ext_data_i));
   // clock
   initial forever #5 ref_clk_i = !ref_clk_i;
   // counts and verdict, then end of run
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one single non-burst access
   // counts strobe-low clocks before ack, clocks from ack to hold
   task automatic access(input logic w);
      int k;
      lo = 0;
      tl = 0;
      rsl = 1'h0;
      @(posedge ref_clk_i);
      strobe_region_select_i <= 1'h1;
      write_i <= w;
      for (k = 0; k < 300; k++) begin
         @(posedge ref_clk_i);
         #1;
         if (transfer_ack_n_o === 1'h0) break;
         if (!read_strobe_n_o) rsl = 1'h1;
         if (!read_strobe_n_o || !write_strobe_n_o) lo++;
      end
      if (k == 300) begin
         mismatches++;
         print_verdict();
      end
      `CHK("buf1", !buf1_on_strobe_cycles_i, buf1_en_n_o)
      `CHK("buf2", !buf2_on_strobe_cycles_i, buf2_en_n_o)
      if (w) `CHK("wdata", wdata_i, ext_data_o)
      `CHK("oe", w, ext_data_oe_o)
      @(posedge ref_clk_i);
      strobe_region_select_i <= 1'h0;
      #1;
      while (hold_active_o !== 1'h1 && tl < 50) begin
         @(posedge ref_clk_i);
         #1;
         tl++;
      end
      if (tl == 50) begin
         mismatches++;
         print_verdict();
      end
      `CHK("oe hold", w, ext_data_oe_o)
      repeat (5) @(posedge ref_clk_i);
   endtask
   // card reads: ack enabled, no handshake, several wait counts
   task automatic card_reads();
      for (int w = 0; w < 3; w++) begin
         read_wait_count_i <= w[7:0];
         access(1'h0);
         `CHK("read lo", w + 2, lo)
         `CHK("read data", PAT, rdata_o)
      end
   endtask
   // writes with post-drive 0, 2 and 3
   task automatic write_post();
      for (int p = 0; p < 4; p++) begin
         if (p == 1) continue;
         strobe_postdrive_count_i <= p[1:0];
         access(1'h1);
         if (p == 0) base = tl;
         `CHK("tail", base + p + (p > 1 ? p - 1 : 0), tl)
         `CHK("write lo", 3, lo)
         `CHK("rd on wr", 1'h0, rsl)
      end
      read_on_write_i <= 1'h1;
      buf1_on_strobe_cycles_i <= 1'h1;
      access(1'h1);
      `CHK("rd on wr", 1'h1, rsl)
      read_on_write_i <= 1'h0;
   endtask
   // requests while block not in charge get nothing
   task automatic refused();
      strobe_region_select_i <= 1'h1;
      for (int c = 0; c < 2; c++) begin
         auto_ack_enable_i <= !c[0];
         ack_generation_enable_i <= !c[0];
         repeat (20) begin
            @(posedge ref_clk_i);
            #1;
            `CHK("refused", 3'h7, {transfer_ack_n_o, read_strobe_n_o,
               write_strobe_n_o})
         end
      end
      @(posedge ref_clk_i);
      strobe_region_select_i <= 1'h0;
      auto_ack_enable_i <= 1'h0;
      ack_generation_enable_i <= 1'h1;
      repeat (5) @(posedge ref_clk_i);
   endtask
   // drive reads with ready handshake, prompt then slow
   task automatic handshake();
      ready_handshake_enable_i <= 1'h1;
      read_wait_count_i <= 8'h03;
      strobe_predrive_count_i <= 3'h3;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         access(1'h0);
         `CHK("stretch", s[0], lo > 5)
         `CHK("hs data", PAT, rdata_o)
      end
      slow <= 1'h0;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'h1;
      card_reads();
      write_post();
      refused();
      handshake();
      print_verdict();
   end
endmodule
